// file: pwf_consts.vh
// Purpose: Shared constants of the PWM frequency and first rise edge block
// Assumes: 25 MHz core clock, 5 ns edge resolution
// Notes:   Register indices are word indices; byte address is index * 4
`ifndef PWF_CONSTS_VH
`define PWF_CONSTS_VH

// ****************************************************************
// Register map (word indices)
// ****************************************************************
`define PWF_IDX_FREQ      8'h40
`define PWF_IDX_RISE_HI   8'h41
`define PWF_IDX_RISE_SET  8'h42
`define PWF_IDX_STATUS    8'h50
`define PWF_ADDR_LSB0     2'b00

// ****************************************************************
// Reset values
// ****************************************************************
`define PWF_RST_FREQ      8'h00
`define PWF_RST_RISE_HI   8'h00
`define PWF_RST_RISE_SET  8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define PWF_FREQ_MSB      5
`define PWF_FREQ_LSB      0
`define PWF_SET_LOW_MSB   7
`define PWF_SET_LOW_LSB   4
`define PWF_SET_MOD_EN    3
`define PWF_SET_SIGN      2
`define PWF_OCT_MSB       5
`define PWF_OCT_LSB       4
`define PWF_STEP_MSB      3
`define PWF_STEP_LSB      0

// ****************************************************************
// Frequency decode
// ****************************************************************
`define PWF_CODE_RESONANT 6'h3f
`define PWF_OCT_BASE      6'h20
`define PWF_OCT3_BASE     5'h10
`define PWF_OCT3_MAXSTEP  4'h6
`define PWF_OCT0          2'b00
`define PWF_OCT1          2'b01
`define PWF_OCT2          2'b10

// ****************************************************************
// Timing
// ****************************************************************
`define PWF_STEP_NS       5
`define PWF_CLK_NS        40
`define PWF_FINE_W        3

`endif

// file: pwf_period_ctr.v
// Purpose: Switching period counter, reloads its length at each wrap
// Assumes: Period length of zero is treated as one cycle
// Notes:   New period length takes effect only at the next period start
`timescale 1ns/1ps
module pwf_period_ctr #(
   parameter W = 10
)(
   input  wire         clk,       // Core clock
   input  wire         rst,       // Synchronous reset, active high
   input  wire         ce,        // Clock enable, freezes state when low
   input  wire [W-1:0] period,    // Period length in clock cycles
   output wire [W-1:0] count,     // Cycle index within the period
   output wire         wrap       // High in the last cycle of a period
);

   localparam [W-1:0] ONE  = 1;
   localparam [W-1:0] ZERO = 0;

   reg  [W-1:0] cnt_r;
   reg  [W-1:0] len_r;
   wire [W-1:0] len_in;

   assign len_in = (period == ZERO) ? ONE : period;
   assign wrap   = (cnt_r >= len_r - ONE);
   assign count  = cnt_r;

   // ****************************************************************
   // Counter
   // ****************************************************************
   always @(posedge clk)
   begin
      if (rst)
      begin
         cnt_r <= {W{1'b0}};
         // Length one makes the first wrap come right after reset
         len_r <= ONE;
      end
      else if (ce)
      begin
         if (wrap)
         begin
            cnt_r <= {W{1'b0}};
            len_r <= len_in;
         end
         else
         begin
            cnt_r <= cnt_r + ONE;
         end
      end
   end

endmodule

// file: pwf_top.v
// Purpose: PWM switching frequency select and first drive rise edge timing
// Assumes: APB slave, 25 MHz clock, inputs synchronous to clk
// Notes:   Sub-cycle part of the edge leaves on rise_fine for a delay line
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "pwf_consts.vh"
module pwf_top #(
   parameter PER_W = 10,
   parameter MOD_W = 12
)(
   input  wire             clk,                   // Core clock, 25 MHz
   input  wire             rst,                   // Sync reset, active high
   input  wire             ce,                    // Clock enable
   input  wire             psel,                  // APB select
   input  wire             penable,               // APB enable
   input  wire             pwrite,                // APB write
   input  wire [9:0]       paddr,                 // APB byte address
   input  wire [31:0]      pwdata,                // APB write data
   output reg  [31:0]      prdata,                // APB read data
   output wire             pready,                // APB ready
   output wire             pslverr,               // APB error
   input  wire [MOD_W-1:0] mod_amount,            // Loop modulation, 5 ns
   input  wire [PER_W-1:0] resonant_period,       // Period in resonant mode
   output reg              first_drive_output,    // First drive output
   output reg  [2:0]       rise_fine,             // Sub-cycle edge offset
   output reg              period_start,          // First cycle of period
   output reg              resonant_mode          // Resonant mode selected
);

   // ****************************************************************
   // Constants
   // ****************************************************************
   localparam [12:0] STEPS_PER_CLK = `PWF_CLK_NS / `PWF_STEP_NS;
   localparam [9:0]  A_FREQ     = {`PWF_IDX_FREQ,     `PWF_ADDR_LSB0};
   localparam [9:0]  A_RISE_HI  = {`PWF_IDX_RISE_HI,  `PWF_ADDR_LSB0};
   localparam [9:0]  A_RISE_SET = {`PWF_IDX_RISE_SET, `PWF_ADDR_LSB0};
   localparam [9:0]  A_STATUS   = {`PWF_IDX_STATUS,   `PWF_ADDR_LSB0};
   localparam [13:0] ZERO14     = 14'h0000;
   localparam [13:0] ONE14      = 14'h0001;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg  [7:0]       freq_r;
   reg  [7:0]       rise_hi_r;
   reg  [7:0]       rise_set_r;
   reg  [12:0]      edge_r;
   reg              out_nxt;
   reg  [13:0]      edge_sum;
   reg  [13:0]      edge_clamp;
   wire [5:0]       freq_code;
   wire [11:0]      rise_time;
   wire             mod_en;
   wire             mod_late;
   wire             is_resonant;
   wire [PER_W-1:0] table_period;
   wire [PER_W-1:0] period_sel;
   wire [PER_W-1:0] cnt;
   wire             wrap;
   wire [12:0]      cnt_steps;
   wire [12:0]      cnt_end;
   wire [13:0]      period_steps;
   wire [13:0]      mod_ext;
   wire             wr_en;
   wire             setup_rd;
   wire             hit;

   // ****************************************************************
   // Frequency decode
   // ****************************************************************
   // Each group of 16 codes is one octave; within it the period in
   // 40 ns cycles falls linearly. The top group steps twice as fast and holds from step 6.
   function [9:0] pwf_period;
      input [5:0] code;
      reg   [5:0] d;
      reg   [3:0] j3;
      reg   [4:0] e;
      begin
         d  = `PWF_OCT_BASE - {2'b00, code[`PWF_STEP_MSB:`PWF_STEP_LSB]};
         j3 = (code[`PWF_STEP_MSB:`PWF_STEP_LSB] > `PWF_OCT3_MAXSTEP) ?
              `PWF_OCT3_MAXSTEP : code[`PWF_STEP_MSB:`PWF_STEP_LSB];
         e  = `PWF_OCT3_BASE - {1'b0, j3};
         case (code[`PWF_OCT_MSB:`PWF_OCT_LSB])
            `PWF_OCT0: pwf_period = {d, 4'h0};
            `PWF_OCT1: pwf_period = {1'b0, d, 3'h0};
            `PWF_OCT2: pwf_period = {2'b00, d, 2'h0};
            default:   pwf_period = {3'b000, e, 2'h0};
         endcase
      end
   endfunction

   assign freq_code    = freq_r[`PWF_FREQ_MSB:`PWF_FREQ_LSB];
   assign is_resonant  = (freq_code == `PWF_CODE_RESONANT);
   assign table_period = pwf_period(freq_code);
   assign period_sel   = is_resonant ? resonant_period : table_period;

   // ****************************************************************
   // Period counter
   // ****************************************************************
   pwf_period_ctr #(
      .W      (PER_W)
   ) u_ctr (
      .clk    (clk),
      .rst    (rst),
      .ce     (ce),
      .period (period_sel),
      .count  (cnt),
      .wrap   (wrap)
   );

   // ****************************************************************
   // Rise edge placement
   // ****************************************************************
   assign rise_time = {rise_hi_r,
      rise_set_r[`PWF_SET_LOW_MSB:`PWF_SET_LOW_LSB]};
   assign mod_en    = rise_set_r[`PWF_SET_MOD_EN];
   assign mod_late  = rise_set_r[`PWF_SET_SIGN];
   assign mod_ext   = {{(14-MOD_W){1'b0}}, mod_amount};
   assign period_steps = {4'h0, period_sel} * {1'b0, STEPS_PER_CLK};

   always @*
   begin
      if (!mod_en)
         edge_sum = {2'b00, rise_time};
      else if (mod_late)
         edge_sum = {2'b00, rise_time} + mod_ext;
      else
         edge_sum = {2'b00, rise_time} - mod_ext;
      // Negative results wrap into bit 13; clamp to start of period
      if (edge_sum[13])
         edge_clamp = ZERO14;
      else if (edge_sum >= period_steps)
         edge_clamp = period_steps - ONE14;
      else
         edge_clamp = edge_sum;
   end

   assign cnt_steps = {3'b000, cnt} * STEPS_PER_CLK;
   assign cnt_end   = cnt_steps + STEPS_PER_CLK;

   // Output rises in the cycle that holds the edge, counted from start; an edge in cycle 0 rises in cycle 1
   always @*
   begin
      if (wrap)
         out_nxt = 1'b0;
      else
         out_nxt = (cnt_end + STEPS_PER_CLK > edge_r);
   end

   // ****************************************************************
   // Output and shadow edge
   // ****************************************************************
   // The edge is captured once per period so that a register write or
   // modulation change never splits a pulse.
   always @(posedge clk)
   begin
      if (rst)
      begin
         edge_r             <= 13'h0000;
         first_drive_output <= 1'b0;
         rise_fine          <= 3'h0;
         period_start       <= 1'b0;
         resonant_mode      <= 1'b0;
      end
      else if (ce)
      begin
         period_start  <= wrap;
         resonant_mode <= is_resonant;
         if (wrap)
         begin
            // Long resonant periods can push the edge past 12 bits
            edge_r    <= edge_clamp[12:0];
            rise_fine <= edge_clamp[`PWF_FINE_W-1:0];
         end
         first_drive_output <= out_nxt;
      end
   end

   // ****************************************************************
   // APB slave
   // ****************************************************************
   assign hit      = (paddr == A_FREQ) || (paddr == A_RISE_HI) ||
                     (paddr == A_RISE_SET) || (paddr == A_STATUS);
   assign pready   = ce;
   assign pslverr  = psel & penable & ~hit;
   assign wr_en    = psel & penable & pwrite & hit & ce;
   assign setup_rd = psel & ~penable & ~pwrite & ce;

   always @(posedge clk)
   begin
      if (rst)
      begin
         freq_r     <= `PWF_RST_FREQ;
         rise_hi_r  <= `PWF_RST_RISE_HI;
         rise_set_r <= `PWF_RST_RISE_SET;
      end
      else if (wr_en)
      begin
         if (paddr == A_FREQ)
            freq_r <= pwdata[7:0];
         if (paddr == A_RISE_HI)
            rise_hi_r <= pwdata[7:0];
         // Reserved low bits stored as written; software keeps them 00
         if (paddr == A_RISE_SET)
            rise_set_r <= pwdata[7:0];
      end
   end

   // Read data is registered in the setup cycle, valid in access phase
   always @(posedge clk)
   begin
      if (rst)
         prdata <= 32'h00000000;
      else if (setup_rd)
      begin
         case (paddr)
            A_FREQ:     prdata <= {24'h000000, freq_r};
            A_RISE_HI:  prdata <= {24'h000000, rise_hi_r};
            A_RISE_SET: prdata <= {24'h000000, rise_set_r};
            A_STATUS:   prdata <= {16'h0000, edge_r[11:0], 1'b0,
                                   period_start, resonant_mode,
                                   first_drive_output};
            default:    prdata <= 32'h00000000;
         endcase
      end
   end

endmodule

// file: pwf_top_chk.sv
// Purpose: Port assertions for pwf_top
// Assumes: ce held high while checked
// Notes:   Mirrors register writes to judge reads
`timescale 1ns/1ps
module pwf_top_chk (
   input wire        clk,                 // Core clock
   input wire        rst,                 // Sync reset
   input wire        ce,                  // Clock enable
   input wire        psel,                // APB select
   input wire        penable,             // APB enable
   input wire        pwrite,              // APB write
   input wire [9:0]  paddr,               // APB address
   input wire [31:0] pwdata,              // APB write data
   input wire [31:0] prdata,              // APB read data
   input wire        pslverr,             // APB error
   input wire        first_drive_output,  // Drive level
   input wire        period_start,        // Period start pulse
   input wire        resonant_mode        // Resonant flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   reg  [7:0]  frq_r, hi_r, set_r;
   // Period starts seen since the last frequency write, saturating
   reg  [1:0]  q_r;
   reg  [9:0]  g_r;
   wire        wr = ce && psel && penable && pwrite;
   wire        rd = ce && psel && penable && !pwrite;
   // ****************************************************************
   // Expected period length per frequency code
   // ****************************************************************
   function [9:0] per_of(input [5:0] c);
      reg [9:0] j;
      begin
         j = {6'h00, c[3:0]};
         case (c[5:4])
            2'b00: per_of = (10'd32 - j) << 4;
            2'b01: per_of = (10'd32 - j) << 3;
            2'b10: per_of = (10'd32 - j) << 2;
            default: per_of = (10'd16 - ((j > 10'd6) ? 10'd6 : j)) << 2;
         endcase
      end
   endfunction
   always @(posedge clk)
   begin
      if (rst)
      begin
         frq_r <= 8'h00;
         hi_r  <= 8'h00;
         set_r <= 8'h00;
         q_r   <= 2'b00;
         g_r   <= 10'h001;
      end
      else if (ce)
      begin
         g_r <= period_start ? 10'h001 : g_r + 10'h001;
         if (period_start && q_r != 2'b11)
            q_r <= q_r + 2'b01;
         if (wr && paddr == 10'h100)
         begin
            frq_r <= pwdata[7:0];
            q_r   <= 2'b00;
         end
         if (wr && paddr == 10'h104)
            hi_r <= pwdata[7:0];
         if (wr && paddr == 10'h108)
            set_r <= pwdata[7:0];
      end
   end
   sequence rd_acc(a);
      rd && paddr == a;
   endsequence
   per_len_a: assert property (
      period_start && !resonant_mode && q_r[1]
      |-> g_r == per_of(frq_r[5:0])) else $error("period length off");
   pulse_once_a: assert property (
      period_start && !resonant_mode |=> !period_start)
      else $error("start pulse too long");
   resonant_a: assert property (
      q_r[1] |-> resonant_mode == (frq_r[5:0] == 6'h3f))
      else $error("resonant flag off");
   start_low_a: assert property (
      period_start |-> !first_drive_output) else $error("drive high at start");
   fall_start_a: assert property (
      $fell(first_drive_output) |-> period_start)
      else $error("drive fell mid period");
   rd_freq_a: assert property (
      rd_acc(10'h100) |-> prdata == {24'h000000, frq_r})
      else $error("frequency read off");
   rd_high_a: assert property (
      rd_acc(10'h104) |-> prdata == {24'h000000, hi_r})
      else $error("rise high read off");
   rd_set_a: assert property (
      rd_acc(10'h108) |-> prdata == {24'h000000, set_r})
      else $error("rise setting read off");
   map_err_a: assert property (
      psel && penable |-> pslverr == !(paddr inside
      {10'h100, 10'h104, 10'h108, 10'h140})) else $error("error flag off");
endmodule
bind pwf_top pwf_top_chk i_chk (.clk(clk), .rst(rst), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .first_drive_output(first_drive_output),
   .period_start(period_start), .resonant_mode(resonant_mode));

// file: pwf_gate_drv.sv
// Purpose: Gate driver model timing the first drive output
// Assumes: start_in marks cycle 0 of each period
// Notes:   Reports last period length and rise cycle
`timescale 1ns/1ps
module pwf_gate_drv (
   input  wire        clk,       // Core clock
   input  wire        drive_in,  // Gate drive level
   input  wire        start_in,  // Period start pulse
   output reg  [15:0] per_len,   // Last full period in cycles
   output reg  [15:0] rise_at    // Rise cycle within period
);
   reg [15:0] cnt_r = 16'h0000;
   reg        prev_r = 1'b0;
   initial
   begin
      per_len = 16'h0000;
      rise_at = 16'h0000;
   end
   always @(posedge clk)
   begin
      prev_r <= drive_in;
      cnt_r <= start_in ? 16'h0001 : cnt_r + 16'h0001;
      if (start_in)
         per_len <= cnt_r;
      if (drive_in && !prev_r)
         rise_at <= cnt_r;
   end
endmodule

// file: pwf_top_test.sv
// Purpose: Self-checking bench for pwf_top
// Assumes: ce held high, APB master tasks
// Notes:   Each row programs a setting and times one period
`timescale 1ns/1ps
module pwf_top_test;
   reg         clk, rst, ce, psel, penable, pwrite, e;
   reg  [9:0]  paddr, rp;
   reg  [31:0] pwdata, d;
   reg  [11:0] mod;
   wire [31:0] prdata;
   wire        pready, pslverr, fdo, ps, rm;
   wire [2:0]  fine;
   wire [15:0] plen, rat;
   integer     failures, check_count, cyc = 0;
   pwf_top i_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mod_amount(mod), .resonant_period(rp), .first_drive_output(fdo),
      .rise_fine(fine), .period_start(ps), .resonant_mode(rm));
   pwf_gate_drv i_gate (.clk(clk), .drive_in(fdo), .start_in(ps),
      .per_len(plen), .rise_at(rat));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task final_report;
      begin
         $display("failures %0d checks %0d", failures, check_count);
         if (failures == 0 && check_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 30000)
      begin
         failures = failures + 1;
         final_report;
      end
   end
   task chk(input [31:0] s, input [31:0] x);
      begin
         check_count = check_count + 1;
         if (s !== x)
         begin
            failures = failures + 1;
            $display("wrong value at %0t: saw %h want %h", $time, s, x);
         end
      end
   endtask
   task xfer(input w, input [9:0] a, input [31:0] v);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= v;
         @(posedge clk);
         penable <= 1'b1;
         do @(posedge clk); while (pready !== 1'b1);
         d = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask
   task run(input [7:0] c, hi, st, input [11:0] m, input [15:0] p,
            input [11:0] ed, input r);
      begin
         mod <= m;
         xfer(1'b1, 10'h100, {24'h000000, c});
         xfer(1'b1, 10'h104, {24'h000000, hi});
         xfer(1'b1, 10'h108, {24'h000000, st});
         repeat (3)
         begin
            do @(posedge clk); while (ps !== 1'b1);
         end
         @(negedge clk);
         chk(plen, p);
         if (r)
            chk(rat, ed >> 3);
         chk(fine, ed[2:0]);
         @(posedge clk);
         xfer(1'b0, 10'h140, 32'h0);
         chk(d[15:4], ed);
         chk(d[1], c[5:0] == 6'h3f);
      end
   endtask
   initial
   begin
      {rst, ce, psel, penable, pwrite, paddr, pwdata, mod} = 0;
      rst = 1'b1;
      ce = 1'b1;
      rp = 10'd40;
      failures = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      xfer(1'b0, 10'h100, 32'h0);
      chk(d, 32'h0);
      xfer(1'b0, 10'h108, 32'h0);
      chk(d, 32'h0);
      xfer(1'b1, 10'h104, 32'h5a5a5aa5);
      xfer(1'b0, 10'h104, 32'h0);
      chk(d, 32'h000000a5);
      xfer(1'b0, 10'h10c, 32'h0);
      chk(d, 32'h0);
      chk({31'h0, e}, 32'h1);
      run(8'h00, 8'h01, 8'h40, 12'd0, 16'd512, 12'd20, 1'b1);
      run(8'h10, 8'h01, 8'h40, 12'd0, 16'd256, 12'd20, 1'b1);
      run(8'h2f, 8'h01, 8'h40, 12'd0, 16'd68, 12'd20, 1'b1);
      run(8'h36, 8'h01, 8'h4c, 12'd9, 16'd40, 12'd29, 1'b1);
      run(8'h36, 8'h01, 8'h48, 12'd9, 16'd40, 12'd11, 1'b1);
      run(8'h36, 8'h01, 8'h44, 12'd9, 16'd40, 12'd20, 1'b1);
      run(8'h36, 8'h10, 8'h00, 12'd0, 16'd40, 12'd256, 1'b1);
      run(8'h36, 8'h00, 8'hf0, 12'd0, 16'd40, 12'd15, 1'b1);
      run(8'h36, 8'hff, 8'hf0, 12'd0, 16'd40, 12'd319, 1'b1);
      run(8'h36, 8'h01, 8'h48, 12'd30, 16'd40, 12'd0, 1'b0);
      run(8'h3f, 8'h01, 8'h40, 12'd0, 16'd40, 12'd20, 1'b1);
      final_report;
   end
endmodule
